/* design/dio_defs.svh */
// Purpose: Offsets, field positions, reset values and sizes for the DIO
//   control block.
// Assumes: 32-bit host I/O port, word aligned.
// Notes: Definitions only.
`ifndef DIO_DEFS_SVH
`define DIO_DEFS_SVH

`define OFS_COUNT_0 6'h00
`define OFS_COUNT_1 6'h04
`define OFS_COUNT_2 6'h08
`define OFS_MODE_WORD 6'h0C
`define OFS_DIN 6'h10
`define OFS_DOUT 6'h14
`define OFS_IRQ 6'h1C

`define BIT_EN_LO 0
`define BIT_PEND_OACK 5
`define BIT_PEND_IREQ 6
`define BIT_PEND_TA 7
`define BIT_PEND_TB 8
`define BIT_PEND_TC 9
`define BIT_A_CASCADE 10
`define BIT_B_CASCADE 11
`define BIT_FALL_SEL 12
`define BIT_FIFO_CLEAR 13
`define BIT_EMPTY 14
`define BIT_FULL 15

`define MODE_SEL_HI 7
`define MODE_SEL_LO 6

`define N_SRC 5
`define N_TIMER 3
`define TIMER_W 16
`define FIFO_AW 11
`define FIFO_DEPTH 12'h800
`define RESET_COUNT 16'hFFFF
`define ZERO32 32'h0000_0000
`define ONE16 16'h0001

`endif

/* design/dio_pkg.sv */
// Purpose: Shared types for the DIO control block.
// Assumes: dio_defs.svh holds the numbers.
// Notes: Mode bits arrive as plain inputs grouped in one struct.
package dio_pkg;

  typedef struct packed {
    logic input_pacer_enable;
    logic in_strobe_enable;
    logic in_ack_enable;
    logic output_pacer_enable;
    logic out_req_enable;
    logic out_ack_enable;
  } mode_s;

  typedef enum logic [1:0] {OUT_IDLE, OUT_REQ, OUT_WAIT_REL} out_state_e;

endpackage : dio_pkg

/* design/dio_transfer_irq_control.sv */
// Purpose: Host-facing control of a 32-bit digital I/O board: timers,
//   interrupt status, input FIFO, input/output strobes and handshakes.
// Assumes: mclk 40 MHz; all pins and the 4 MHz reference are asynchronous.
// Notes: Host port is a single-cycle strobe port, read data one cycle later.
// Operation
// - Low five bits of interrupt register enable the five event sources.
// - Pending bits 5..9 report ack, request and three timer events.
// - Writing one clears a pending bit; zero leaves it alone.
// - Timer A counts timer C output when cascaded, else 4 MHz.
// - Timer B counts timer C output when cascaded, else 4 MHz.
// - Strobe-only sampling latches on falling edge if polarity bit set.
// - Writing one to the clear bit empties the input FIFO.
// - Empty and full flags read back the input FIFO state.
// - Input FIFO holds 2k words, ahead of the bus controller FIFO.
// - Counters at offsets 0, 4, 8; write-only mode word at C.
// - Input port reads the lines; output port write drives them.
// - Timer A paces input sampling, timer B paces output updates.
// - Each pacer pulse stores one sample, drained toward host memory.
// - Each external request strobe stores one sample in the FIFO.
// - Data stored first, then input acknowledge raised.
// - Drain FIFO whenever non-empty, the host bus is free and the drain stage is empty or accepted.
// - Present output word, raise request, await acknowledge, repeat.
// - Output words are pulled when the source offers one, the output path is idle and, with the output pacer on, timer B output falls.
// - Request held until acknowledge; acknowledge held until release.
// - Input pacer samples on falling edge of timer A output.
`include "dio_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module dio_transfer_irq_control (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [5:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [31:0] io_wdata,
  output logic [31:0] io_rdata,
  input wire dio_pkg::mode_s mode,
  input wire logic ref_clk_4m,
  input wire logic [31:0] din_pins,
  input wire logic in_req_pin,
  output logic in_ack_pin,
  output logic [31:0] dout_pins,
  output logic out_req_pin,
  input wire logic out_ack_pin,
  input wire logic bus_free,
  output logic in_dma_valid,
  output logic [31:0] in_dma_data,
  input wire logic in_dma_ready,
  input wire logic out_src_valid,
  input wire logic [31:0] out_src_data,
  output logic out_src_ready,
  output logic irq,
  output logic fifo_empty_flag,
  output logic fifo_full_flag
);
  import dio_pkg::*;

  // Two-flop synchronisers; stage one is read only by stage two
  logic [31:0] din_s1_reg, din_s2_reg;
  logic [2:0] ctl_s1_reg, ctl_s2_reg, ctl_prev_reg;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      din_s1_reg <= `ZERO32;
      din_s2_reg <= `ZERO32;
      ctl_s1_reg <= 3'h0;
      ctl_s2_reg <= 3'h0;
      ctl_prev_reg <= 3'h0;
    end else if (ce) begin
      din_s1_reg <= din_pins;
      din_s2_reg <= din_s1_reg;
      ctl_s1_reg <= {ref_clk_4m, out_ack_pin, in_req_pin};
      ctl_s2_reg <= ctl_s1_reg;
      ctl_prev_reg <= ctl_s2_reg;
    end
  end

  wire req_lvl = ctl_s2_reg[0];
  wire req_rise = ctl_s2_reg[0] & ~ctl_prev_reg[0];
  wire req_fall = ~ctl_s2_reg[0] & ctl_prev_reg[0];
  wire ack_rise = ctl_s2_reg[1] & ~ctl_prev_reg[1];
  wire ref_tick = ctl_s2_reg[2] & ~ctl_prev_reg[2];

  // Host decode
  wire wr_cnt0 = io_wr && io_addr == `OFS_COUNT_0;
  wire wr_cnt1 = io_wr && io_addr == `OFS_COUNT_1;
  wire wr_cnt2 = io_wr && io_addr == `OFS_COUNT_2;
  wire wr_mode = io_wr && io_addr == `OFS_MODE_WORD;
  wire wr_dout = io_wr && io_addr == `OFS_DOUT;
  wire wr_irq = io_wr && io_addr == `OFS_IRQ;
  wire [2:0] wr_cnt = {wr_cnt2, wr_cnt1, wr_cnt0};

  // Control register fields
  logic [`N_SRC-1:0] irq_en_reg, pend_reg, pend_next, pend_set;
  logic a_casc_reg, b_casc_reg, fall_sel_reg;
  wire fifo_clear = wr_irq & io_wdata[`BIT_FIFO_CLEAR];

  // Timers: 16-bit reload down-counters; output dips low for one tick
  logic [`TIMER_W-1:0] cnt_reg [`N_TIMER];
  logic [`TIMER_W-1:0] reload_reg [`N_TIMER];
  logic [2:0] tout_reg, tout_prev_reg;
  logic [2:0] tick;
  logic [1:0] mode_sel;
  wire tc_rise = tout_reg[2] & ~tout_prev_reg[2];
  assign mode_sel = io_wdata[`MODE_SEL_HI:`MODE_SEL_LO];
  assign tick[0] = a_casc_reg ? tc_rise : ref_tick;
  assign tick[1] = b_casc_reg ? tc_rise : ref_tick;
  assign tick[2] = ref_tick;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      for (int i = 0; i < `N_TIMER; i++) begin
        cnt_reg[i] <= `RESET_COUNT;
        reload_reg[i] <= `RESET_COUNT;
      end
      tout_reg <= 3'h7;
      tout_prev_reg <= 3'h7;
    end else if (ce) begin
      tout_prev_reg <= tout_reg;
      for (int i = 0; i < `N_TIMER; i++) begin
        if (wr_cnt[i]) begin
          reload_reg[i] <= io_wdata[`TIMER_W-1:0];
          cnt_reg[i] <= io_wdata[`TIMER_W-1:0];
          tout_reg[i] <= 1'b1;
        end else if (wr_mode && mode_sel == 2'(i)) begin
          // Mode word restarts the selected counter from its reload
          cnt_reg[i] <= reload_reg[i];
          tout_reg[i] <= 1'b1;
        end else if (tick[i]) begin
          if (cnt_reg[i] <= `ONE16) begin
            cnt_reg[i] <= reload_reg[i];
            tout_reg[i] <= 1'b0;
          end else begin
            cnt_reg[i] <= cnt_reg[i] - `ONE16;
            tout_reg[i] <= 1'b1;
          end
        end
      end
    end
  end

  wire [2:0] tout_rise = tout_reg & ~tout_prev_reg;
  wire [2:0] tout_fall = ~tout_reg & tout_prev_reg;

  // Input sample events
  wire strobe_edge = fall_sel_reg ? req_fall : req_rise;
  wire pacer_edge = mode.input_pacer_enable & tout_fall[0];
  wire strobe_evt = mode.in_strobe_enable & strobe_edge;
  wire sample_evt = pacer_edge | strobe_evt;

  // On-board 2k input FIFO; overflowing samples are dropped
  logic [31:0] fifo_mem [`FIFO_DEPTH];
  logic [`FIFO_AW-1:0] wr_ptr_reg, rd_ptr_reg;
  logic [`FIFO_AW:0] level_reg;
  logic in_dma_valid_reg;
  wire fifo_full = level_reg == `FIFO_DEPTH;
  wire fifo_empty = level_reg == '0;
  wire push = sample_evt & ~fifo_full;
  wire stage_free = ~in_dma_valid_reg | in_dma_ready;
  wire pop = ~fifo_empty & bus_free & stage_free;

  always_ff @(posedge mclk) begin
    if (ce && push) begin
      fifo_mem[wr_ptr_reg] <= din_s2_reg;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      level_reg <= '0;
      in_dma_valid_reg <= 1'b0;
      in_dma_data <= `ZERO32;
    end else if (ce) begin
      if (fifo_clear) begin
        wr_ptr_reg <= '0;
        rd_ptr_reg <= '0;
        level_reg <= '0;
        in_dma_valid_reg <= 1'b0;
      end else begin
        if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
        if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
        level_reg <= level_reg + {11'h0, push} - {11'h0, pop};
        if (pop) begin
          in_dma_valid_reg <= 1'b1;
          in_dma_data <= fifo_mem[rd_ptr_reg];
        end else if (in_dma_ready) begin
          in_dma_valid_reg <= 1'b0;
        end
      end
    end
  end
  assign in_dma_valid = in_dma_valid_reg;

  // Input acknowledge: raised after the store, held until request drops
  wire req_active = fall_sel_reg ? ~req_lvl : req_lvl;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      in_ack_pin <= 1'b0;
    end else if (ce) begin
      if (!mode.in_ack_enable) begin
        in_ack_pin <= 1'b0;
      end else if (push && strobe_evt) begin
        in_ack_pin <= 1'b1;
      end else if (in_ack_pin && !req_active) begin
        in_ack_pin <= 1'b0;
      end
    end
  end

  // Output path: host write, pacer or request/acknowledge handshake
  out_state_e out_state_reg;
  wire out_go = mode.output_pacer_enable ? tout_fall[1] : 1'b1;
  wire out_take = out_src_valid & out_go & out_state_reg == OUT_IDLE;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      out_state_reg <= OUT_IDLE;
      dout_pins <= `ZERO32;
      out_req_pin <= 1'b0;
      out_src_ready <= 1'b0;
    end else if (ce) begin
      out_src_ready <= 1'b0;
      case (out_state_reg)
        OUT_IDLE: begin
          out_req_pin <= 1'b0;
          if (wr_dout) begin
            dout_pins <= io_wdata;
          end else if (out_take && !out_src_ready) begin
            dout_pins <= out_src_data;
            out_src_ready <= 1'b1;
            if (mode.out_req_enable) out_state_reg <= OUT_REQ;
          end
        end
        OUT_REQ: begin
          out_req_pin <= 1'b1;
          if (!mode.out_ack_enable) begin
            out_state_reg <= OUT_WAIT_REL;
          end else if (ack_rise) begin
            out_state_reg <= OUT_WAIT_REL;
          end
        end
        OUT_WAIT_REL: begin
          out_req_pin <= 1'b0;
          out_state_reg <= OUT_IDLE;
        end
        default: out_state_reg <= OUT_IDLE;
      endcase
    end
  end

  // Interrupt status: set wins over a simultaneous one-write clear
  assign pend_set = {tout_rise[2], tout_rise[1], tout_rise[0],
                     strobe_edge, ack_rise};
  wire [`N_SRC-1:0] clr_mask = wr_irq ?
    io_wdata[`BIT_PEND_TC:`BIT_PEND_OACK] : '0;
  assign pend_next = (pend_reg & ~clr_mask) | pend_set;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      irq_en_reg <= '0;
      pend_reg <= '0;
      a_casc_reg <= 1'b0;
      b_casc_reg <= 1'b0;
      fall_sel_reg <= 1'b0;
      irq <= 1'b0;
      fifo_empty_flag <= 1'b1;
      fifo_full_flag <= 1'b0;
    end else if (ce) begin
      pend_reg <= pend_next;
      if (wr_irq) begin
        irq_en_reg <= io_wdata[`N_SRC-1:`BIT_EN_LO];
        a_casc_reg <= io_wdata[`BIT_A_CASCADE];
        b_casc_reg <= io_wdata[`BIT_B_CASCADE];
        fall_sel_reg <= io_wdata[`BIT_FALL_SEL];
      end
      irq <= |(pend_next & irq_en_reg);
      fifo_empty_flag <= fifo_empty;
      fifo_full_flag <= fifo_full;
    end
  end

  // Read mux; clear bit reads as zero since it is write-only
  logic [31:0] irq_word;
  always_comb begin
    irq_word = `ZERO32;
    irq_word[`N_SRC-1:`BIT_EN_LO] = irq_en_reg;
    irq_word[`BIT_PEND_TC:`BIT_PEND_OACK] = pend_reg;
    irq_word[`BIT_A_CASCADE] = a_casc_reg;
    irq_word[`BIT_B_CASCADE] = b_casc_reg;
    irq_word[`BIT_FALL_SEL] = fall_sel_reg;
    irq_word[`BIT_EMPTY] = fifo_empty;
    irq_word[`BIT_FULL] = fifo_full;
  end

  wire [31:0] rd_word =
    io_addr == `OFS_COUNT_0 ? {16'h0000, cnt_reg[0]} :
    io_addr == `OFS_COUNT_1 ? {16'h0000, cnt_reg[1]} :
    io_addr == `OFS_COUNT_2 ? {16'h0000, cnt_reg[2]} :
    io_addr == `OFS_DIN ? din_s2_reg :
    io_addr == `OFS_DOUT ? dout_pins :
    io_addr == `OFS_IRQ ? irq_word : `ZERO32;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      io_rdata <= `ZERO32;
    end else if (ce && io_rd) begin
      io_rdata <= rd_word;
    end
  end

endmodule : dio_transfer_irq_control

`default_nettype wire

/* test/dio_transfer_irq_control_monitor.sv */
// Purpose: Port checker for the DIO control block.
// Assumes: one clock domain, mclk.
// Notes: Bound to the design below.
`timescale 1ns/1ps
`default_nettype none
module dio_transfer_irq_control_monitor (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic io_rd,
  input wire logic [31:0] io_rdata,
  input wire dio_pkg::mode_s mode,
  input wire logic in_req_pin,
  input wire logic in_ack_pin,
  input wire logic out_req_pin,
  input wire logic out_ack_pin,
  input wire logic out_src_valid,
  input wire logic out_src_ready,
  input wire logic in_dma_valid,
  input wire logic [31:0] in_dma_data,
  input wire logic in_dma_ready,
  input wire logic fifo_empty_flag,
  input wire logic fifo_full_flag
);
  import dio_pkg::*;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  a_flags_excl:
    assert property (!(fifo_empty_flag && fifo_full_flag))
    else $error("empty and full");
  a_ack_cause:
    assert property ($rose(in_ack_pin) |-> $past(mode.in_ack_enable))
    else $error("ack while disabled");
  a_ack_hold:
    assert property (in_ack_pin && in_req_pin |=> in_ack_pin)
    else $error("ack dropped early");
  a_ack_release:
    assert property ((!in_req_pin)[*8] |-> !in_ack_pin)
    else $error("ack held too long");
  a_oreq_wait:
    assert property ((mode.out_ack_enable && out_req_pin && !out_ack_pin)[*3]
      |=> out_req_pin)
    else $error("request dropped early");
  a_oreq_gap:
    assert property ($fell(out_req_pin) |=> !out_req_pin)
    else $error("request gap missing");
  a_src_cause:
    assert property (out_src_ready |-> $past(out_src_valid))
    else $error("word taken unoffered");
  a_drain_hold:
    assert property (in_dma_valid && !in_dma_ready |=>
      in_dma_valid && $stable(in_dma_data))
    else $error("drain word moved");
  a_rdata_hold:
    assert property (!io_rd |=> $stable(io_rdata))
    else $error("read data moved");
endmodule : dio_transfer_irq_control_monitor

bind dio_transfer_irq_control dio_transfer_irq_control_monitor u_mon (
  .mclk, .rst_b, .io_rd, .io_rdata, .mode, .in_req_pin, .in_ack_pin,
  .out_req_pin, .out_ack_pin, .out_src_valid, .out_src_ready,
  .in_dma_valid, .in_dma_data, .in_dma_ready, .fifo_empty_flag,
  .fifo_full_flag);
`default_nettype wire

/* test/dio_ext_device.sv */
// Purpose: Far-side parallel device for the DIO control block.
// Assumes: drives its pins just after falling mclk.
// Notes: Released input lines show the inverse of the last word.
`timescale 1ns/1ps
`default_nettype none
module dio_ext_device (
  input wire logic mclk,
  input wire logic in_ack_pin,
  input wire logic out_req_pin,
  input wire logic [31:0] dout_pins,
  output var logic [31:0] din_pins,
  output var logic in_req_pin,
  output var logic out_ack_pin
);
  logic [31:0] seen[$];
  int errs = 0;
  int n;
  initial begin
    din_pins = 32'h0;
    in_req_pin = 1'b0;
    out_ack_pin = 1'b0;
  end
  // With neg set the lines hold the inverse at the rising edge, so a
  // rising-edge latch cannot pass for a falling-edge one
  task automatic strobe(input logic [31:0] v, input bit hs, input bit neg);
    int w = 0;
    @(negedge mclk);
    din_pins = neg ? ~v : v;
    repeat (2) @(negedge mclk);
    in_req_pin = 1'b1;
    if (!hs) repeat (2) @(negedge mclk);
    din_pins = v;
    if (!hs) @(negedge mclk);
    while (hs && !in_ack_pin && w < 40) begin
      @(negedge mclk);
      w++;
    end
    if (w == 40) errs++;
    in_req_pin = 1'b0;
    repeat (3) @(negedge mclk);
    din_pins = ~v;
    repeat (3) @(negedge mclk);
  endtask : strobe
  // Ack delay varies so both prompt and slow answers occur
  always begin
    @(posedge out_req_pin);
    seen.push_back(dout_pins);
    repeat ($urandom_range(4) + 1) @(negedge mclk);
    out_ack_pin = 1'b1;
    n = 0;
    while (out_req_pin && n < 40) begin
      @(negedge mclk);
      n++;
    end
    if (n == 40) errs++;
    out_ack_pin = 1'b0;
  end
endmodule : dio_ext_device
`default_nettype wire

/* test/dio_transfer_irq_control_bench.sv */
// Purpose: Self-checking bench for the DIO control block.
// Assumes: far-side model drives the strobe pins.
// Notes: Expected words come from bench queues.
`timescale 1ns/1ps
`default_nettype none
module dio_transfer_irq_control_bench;
  import dio_pkg::*;
  logic mclk, ref_clk_4m, rst_b = 1'b0, ce = 1'b1, io_wr = 1'b0;
  logic io_rd = 1'b0, bus_free = 1'b0, in_dma_ready = 1'b0;
  logic out_src_valid = 1'b0, drain = 1'b0, pace = 1'b0;
  logic [5:0] io_addr = 6'h00;
  logic [31:0] io_wdata = 32'h0, out_src_data = 32'h0, d, v, pace_v;
  logic [31:0] io_rdata, din_pins, dout_pins, in_dma_data;
  logic in_req_pin, in_ack_pin, out_req_pin, out_ack_pin, in_dma_valid;
  logic out_src_ready, irq, fifo_empty_flag, fifo_full_flag;
  mode_s mode = 6'h00;
  logic [31:0] exp_in[$], out_q[$], exp_out[$];
  int mismatches = 0, tests_run = 0, k;
  dio_transfer_irq_control uut (.mclk, .rst_b, .ce, .io_addr, .io_wr, .io_rd,
    .io_wdata, .io_rdata, .mode, .ref_clk_4m, .din_pins, .in_req_pin,
    .in_ack_pin, .dout_pins, .out_req_pin, .out_ack_pin, .bus_free,
    .in_dma_valid, .in_dma_data, .in_dma_ready, .out_src_valid,
    .out_src_data, .out_src_ready, .irq, .fifo_empty_flag, .fifo_full_flag);
  dio_ext_device far (.mclk, .in_ack_pin, .out_req_pin, .dout_pins,
    .din_pins, .in_req_pin, .out_ack_pin);
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    ref_clk_4m = 1'b0;
    #7;
    forever #125 ref_clk_4m = ~ref_clk_4m;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [31:0] x);
    @(negedge mclk);
    io_addr = a;
    io_wdata = x;
    io_wr = 1'b1;
    @(negedge mclk);
    io_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a);
    @(negedge mclk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge mclk);
    io_rd = 1'b0;
    d = io_rdata;
  endtask : rd
  function automatic bit cond(input int w);
    case (w)
      0: return irq === 1'b1;
      1: return exp_in.size() == 0 && fifo_empty_flag && !in_dma_valid;
      default: return far.seen.size() == exp_out.size();
    endcase
  endfunction : cond
  task automatic waitc(input int w);
    int n = 0;
    while (!cond(w) && n < 400) begin
      @(negedge mclk);
      n++;
    end
    if (n == 400) begin
      mismatches++;
      complete_run();
    end
  endtask : waitc
  // Idle source data is inverted so stale words cannot pass
  always @(negedge mclk) begin
    bus_free <= drain && ($urandom_range(3) != 0);
    in_dma_ready <= drain && ($urandom_range(1) == 1);
    out_src_valid <= out_q.size() != 0;
    out_src_data <= (out_q.size() != 0) ? out_q[0] : ~out_src_data;
  end
  always @(posedge mclk) begin
    if (out_src_ready === 1'b1) out_q.delete(0);
    if (in_dma_valid === 1'b1 && in_dma_ready) begin
      if (pace) chk(in_dma_data, pace_v);
      else chk(in_dma_data, exp_in.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    complete_run();
  end
  initial begin
    void'($urandom(32'h2DC4));
    repeat (6) @(negedge mclk);
    rst_b = 1'b1;
    rd(6'h1C);
    chk(d, 32'h0000_4000);
    rd(6'h0C);
    chk(d, 32'h0);
    rd(6'h04);
    chk(d & 32'hFFFF_0000, 32'h0);
    for (k = 0; k < 4; k++) begin
      v = $urandom & 32'h3C1F;
      wr(6'h1C, v);
      rd(6'h1C);
      chk(d, (v & 32'h1C1F) | 32'h4000);
    end
    // Clock enable low must swallow the write
    ce = 1'b0;
    wr(6'h1C, 32'h1F);
    ce = 1'b1;
    rd(6'h1C);
    chk(d & 32'h1F, v & 32'h1F);
    $display("test registers done");
    wr(6'h1C, 32'h0);
    v = $urandom;
    far.strobe(v, 1'b0, 1'b0);
    rd(6'h10);
    chk(d, ~v);
    rd(6'h1C);
    chk(d, 32'h0000_4040);
    wr(6'h1C, 32'h0);
    rd(6'h1C);
    chk(d, 32'h0000_4040);
    wr(6'h1C, 32'h40);
    rd(6'h1C);
    chk(d, 32'h0000_4000);
    wr(6'h14, v);
    chk(dout_pins, v);
    $display("test direct ports done");
    wr(6'h00, 32'h5);
    wr(6'h1C, 32'h4);
    waitc(0);
    rd(6'h1C);
    chk(d & 32'h80, 32'h80);
    wr(6'h1C, 32'h404);
    repeat (30) @(negedge mclk);
    wr(6'h1C, 32'h484);
    repeat (200) @(negedge mclk);
    rd(6'h1C);
    chk(d, 32'h0000_4404);
    chk({31'h0, irq}, 32'h0);
    wr(6'h1C, 32'h84);
    waitc(0);
    wr(6'h1C, 32'h0);
    repeat (2) @(negedge mclk);
    chk({31'h0, irq}, 32'h0);
    $display("test timers done");
    mode.in_strobe_enable = 1'b1;
    mode.in_ack_enable = 1'b1;
    drain = 1'b1;
    for (k = 0; k < 8; k++) begin
      if (k == 5) begin
        mode.in_ack_enable = 1'b0;
        wr(6'h1C, 32'h1040);
      end
      v = $urandom;
      exp_in.push_back(v);
      far.strobe(v, k < 5, k >= 5);
    end
    waitc(1);
    wr(6'h1C, 32'h40);
    drain = 1'b0;
    repeat (3) begin
      v = $urandom;
      far.strobe(v, 1'b0, 1'b0);
    end
    rd(6'h1C);
    chk(d & 32'h4000, 32'h0);
    wr(6'h1C, 32'h2000);
    repeat (2) @(negedge mclk);
    chk({31'h0, fifo_empty_flag}, 32'h1);
    drain = 1'b1;
    $display("test input strobes done");
    pace_v = ~v;
    pace = 1'b1;
    mode = 6'h20;
    k = tests_run;
    repeat (300) @(negedge mclk);
    mode = 6'h00;
    waitc(1);
    pace = 1'b0;
    chk({31'h0, tests_run > k + 1}, 32'h1);
    $display("test pacer done");
    mode = 6'h03;
    for (k = 0; k < 4; k++) begin
      v = $urandom;
      out_q.push_back(v);
      exp_out.push_back(v);
    end
    waitc(2);
    for (k = 0; k < 4; k++) chk(far.seen[k], exp_out[k]);
    rd(6'h1C);
    chk(d & 32'h20, 32'h20);
    chk(32'(far.errs), 32'h0);
    $display("test output handshake done");
    // Timer B still far from its first reload: nothing may go out yet
    mode = 6'h06;
    v = $urandom;
    out_q.push_back(v);
    exp_out.push_back(v);
    repeat (100) @(negedge mclk);
    chk(32'(far.seen.size()), 32'h4);
    wr(6'h04, 32'h3);
    waitc(2);
    chk(far.seen[4], v);
    $display("test output pacer done");
    complete_run();
  end
endmodule : dio_transfer_irq_control_bench
`default_nettype wire
